// [verilog/trim_port_cfg.svh]
`ifndef TRIM_PORT_CFG_SVH
`define TRIM_PORT_CFG_SVH

`define CLK_MHZ           125
`define READ_LATENCY_US   200
`define READ_LATENCY_CYC  (`READ_LATENCY_US * `CLK_MHZ)
`define REFRESH_HZ        400
`define REFRESH_CYC       ((`CLK_MHZ * 1000000) / `REFRESH_HZ)

`define WAKE_LEN          6
`define WORD_LEN          16
`define STORE_BITS        128
`define STORE_WORD_BITS   16
`define DATA_W            12
`define ADDR_W            7

`define CFG_WORD          0
`define OFFSET_WORD       1
`define OTC_WORD          2
`define SPAN_WORD         3
`define STC_WORD          4

`define WAKE_U_POS        4

`endif

// [verilog/trim_port_pkg.sv]
`default_nettype none
package trim_port_pkg;

   typedef enum logic [3:0] {
      CMD_NOP        = 4'h0,
      CMD_ERASE      = 4'h1,
      CMD_PROG_BEGIN = 4'h2,
      CMD_READ       = 4'h3,
      CMD_RSVD       = 4'h4,
      CMD_PROG_END   = 4'h5,
      CMD_LOAD_6     = 4'h6,
      CMD_LOAD_7     = 4'h7,
      CMD_WR_CFG     = 4'h8,
      CMD_WR_OFFSET  = 4'h9,
      CMD_WR_OTC     = 4'ha,
      CMD_WR_SPAN    = 4'hb,
      CMD_WR_STC     = 4'hc,
      CMD_LOAD_D     = 4'hd,
      CMD_LOAD_E     = 4'he,
      CMD_LOAD_F     = 4'hf
   } cmd_t;

   typedef struct packed {
      cmd_t        command_field_bits;
      logic [11:0] data_field_bits;
   } ctrl_word_t;

   // Gain select: bit 2 is the most significant
   typedef struct packed {
      logic [2:0] coarse_input_offset_mag;
      logic       coarse_input_offset_sign;
      logic       internal_resistor_select;
      logic [1:0] reserved;
      logic [2:0] gain_select;
      logic       offset_polarity;
      logic       offset_tempco_polarity;
   } config_t;

   typedef struct packed {
      logic [11:0] span_tempco;
      logic [11:0] span;
      logic [11:0] offset_tempco;
      logic [11:0] offset;
   } dac_set_t;

   typedef enum logic [1:0] {
      LK_WAKE  = 2'b00,
      LK_WORDS = 2'b01,
      LK_DEAD  = 2'b10
   } link_state_t;

endpackage
`default_nettype wire

// [verilog/trim_serial_command_port.sv]
`timescale 1ns/1ns
`default_nettype none
`include "trim_port_cfg.svh"
module trim_serial_command_port
   import trim_port_pkg::*;
#(
   parameter int unsigned READ_LATENCY_CYC = `READ_LATENCY_CYC,
   parameter int unsigned REFRESH_CYC      = `REFRESH_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sclk,
   input  wire logic chip_select,
   input  wire logic write_enable,
   input  wire logic serial_data_line_in,
   output var  logic serial_data_line_out,
   output var  logic serial_data_line_oe_n,
   output var  logic analog_out_en,
   output var  logic session_open,
   output var  config_t config_reg,
   output var  dac_set_t dac_regs
);

   function automatic logic wake_ok(input logic [5:0] w);
      return w[0] & ~w[1] & w[2] & ~w[3] & ~w[5];
   endfunction

   function automatic logic [11:0] store_field(
      input logic [`STORE_BITS-1:0] s,
      input int unsigned            idx
   );
      return s[idx*`STORE_WORD_BITS +: `DATA_W];
   endfunction

   function automatic logic is_load(input cmd_t c);
      return (c == CMD_LOAD_6) || (c == CMD_LOAD_7) || (c == CMD_LOAD_D) ||
             (c == CMD_LOAD_E) || (c == CMD_LOAD_F);
   endfunction

   // Link domain, on the host's serial clock
   // Deselect resets the link side, so no sclk edge is needed to restart
   logic        link_rst_n;
   link_state_t lk_state_q;
   logic [15:0] lk_shift_q;
   logic [15:0] lk_shift_d;
   logic [4:0]  lk_cnt_q;
   logic        lk_u_q;
   logic        lk_open_q;
   ctrl_word_t  lk_word_q;
   logic        lk_tgl_q;

   assign link_rst_n = rst_n & chip_select;
   assign lk_shift_d = {serial_data_line_in, lk_shift_q[15:1]};

   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lk_state_q <= LK_WAKE;
         lk_shift_q <= '0;
         lk_cnt_q   <= '0;
         lk_u_q     <= 1'b0;
         lk_open_q  <= 1'b0;
      end else begin
         lk_shift_q <= lk_shift_d;
         case (lk_state_q)
            LK_WAKE: begin
               if (lk_cnt_q == 5'(`WAKE_LEN - 1)) begin
                  lk_cnt_q <= '0;
                  if (wake_ok(lk_shift_d[15:10])) begin
                     lk_state_q <= LK_WORDS;
                     lk_open_q  <= 1'b1;
                     lk_u_q     <= lk_shift_d[10 + `WAKE_U_POS];
                  end else begin
                     lk_state_q <= LK_DEAD;
                  end
               end else begin
                  lk_cnt_q <= lk_cnt_q + 5'd1;
               end
            end
            LK_WORDS: begin
               if (lk_cnt_q == 5'(`WORD_LEN - 1)) begin
                  lk_cnt_q <= '0;
               end else begin
                  lk_cnt_q <= lk_cnt_q + 5'd1;
               end
            end
            default: begin
               lk_state_q <= LK_DEAD;
            end
         endcase
      end
   end

   // Word handoff survives deselect so a reset cannot fake a toggle
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         lk_word_q <= '0;
         lk_tgl_q  <= 1'b0;
      end else if (lk_state_q == LK_WORDS && lk_cnt_q == 5'(`WORD_LEN - 1)) begin
         lk_word_q <= ctrl_word_t'(lk_shift_d);
         lk_tgl_q  <= ~lk_tgl_q;
      end
   end

   // Synchronisers into clk
   logic cs_meta_q;
   logic cs_s_q;
   logic cs_d_q;
   logic we_meta_q;
   logic we_s_q;
   logic open_meta_q;
   logic open_s_q;
   logic open_d_q;
   logic tgl_meta_q;
   logic tgl_s_q;
   logic tgl_d_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_meta_q <= 1'b0;
         cs_s_q    <= 1'b0;
         cs_d_q    <= 1'b0;
         we_meta_q <= 1'b0;
         we_s_q    <= 1'b0;
      end else begin
         cs_meta_q <= chip_select;
         cs_s_q    <= cs_meta_q;
         cs_d_q    <= cs_s_q;
         we_meta_q <= write_enable;
         we_s_q    <= we_meta_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         open_meta_q <= 1'b0;
         open_s_q    <= 1'b0;
         open_d_q    <= 1'b0;
         tgl_meta_q  <= 1'b0;
         tgl_s_q     <= 1'b0;
         tgl_d_q     <= 1'b0;
      end else begin
         open_meta_q <= lk_open_q;
         open_s_q    <= open_meta_q;
         open_d_q    <= open_s_q;
         tgl_meta_q  <= lk_tgl_q;
         tgl_s_q     <= tgl_meta_q;
         tgl_d_q     <= tgl_s_q;
      end
   end

   logic       cs_rise;
   logic       cs_fall;
   logic       open_rise;
   logic       word_ok;
   logic       prog_ok;
   ctrl_word_t word;
   cmd_t       cmd;
   logic [6:0] bit_addr;

   assign cs_rise   = cs_s_q & ~cs_d_q;
   assign cs_fall   = ~cs_s_q & cs_d_q;
   assign open_rise = open_s_q & ~open_d_q;
   // Word is stable for 16 sclk periods after its toggle, far above the sync delay
   assign word      = lk_word_q;
   assign cmd       = word.command_field_bits;
   assign bit_addr  = word.data_field_bits[`ADDR_W-1:0];
   assign word_ok   = (tgl_s_q ^ tgl_d_q) & cs_s_q & open_s_q;
   assign prog_ok   = word_ok & we_s_q & cs_s_q;

   assign analog_out_en = cs_s_q;
   assign session_open  = open_s_q;

   // Update-inhibit bit, taken when a session opens
   logic inhibit_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inhibit_q <= 1'b0;
      end else if (open_rise) begin
         inhibit_q <= lk_u_q;
      end
   end

   // Periodic refresh while write_enable is high, halted once a session is open
   logic [31:0] refr_cnt_q;
   logic        refr_tick;

   assign refr_tick = we_s_q & ~open_s_q & (refr_cnt_q == 32'(REFRESH_CYC - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refr_cnt_q <= '0;
      end else if (!we_s_q || open_s_q || refr_tick) begin
         refr_cnt_q <= '0;
      end else begin
         refr_cnt_q <= refr_cnt_q + 32'd1;
      end
   end

   logic reload;

   assign reload = (cs_rise & ~inhibit_q) | refr_tick;

   // Store model; reset stands in for the blank part
   logic [`STORE_BITS-1:0] store_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         store_q <= '0;
      end else if (prog_ok) begin
         case (cmd)
            CMD_ERASE: begin
               store_q <= '0;
            end
            CMD_PROG_BEGIN: begin
               store_q[bit_addr] <= 1'b1;
            end
            default: begin
               store_q <= store_q;
            end
         endcase
      end
   end

   // Pending values wait for a load-register command
   config_t  pend_cfg_q;
   dac_set_t pend_dac_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_cfg_q <= '0;
         pend_dac_q <= '0;
      end else if (reload) begin
         pend_cfg_q               <= config_t'(store_field(store_q, `CFG_WORD));
         pend_dac_q.offset        <= store_field(store_q, `OFFSET_WORD);
         pend_dac_q.offset_tempco <= store_field(store_q, `OTC_WORD);
         pend_dac_q.span          <= store_field(store_q, `SPAN_WORD);
         pend_dac_q.span_tempco   <= store_field(store_q, `STC_WORD);
      end else if (word_ok) begin
         case (cmd)
            CMD_WR_CFG: begin
               pend_cfg_q <= config_t'(word.data_field_bits);
            end
            CMD_WR_OFFSET: begin
               pend_dac_q.offset <= word.data_field_bits;
            end
            CMD_WR_OTC: begin
               pend_dac_q.offset_tempco <= word.data_field_bits;
            end
            CMD_WR_SPAN: begin
               pend_dac_q.span <= word.data_field_bits;
            end
            CMD_WR_STC: begin
               pend_dac_q.span_tempco <= word.data_field_bits;
            end
            default: begin
               pend_cfg_q <= pend_cfg_q;
            end
         endcase
      end
   end

   // Active registers feeding the analog trim
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         config_reg <= '0;
         dac_regs   <= '0;
      end else if (reload) begin
         config_reg             <= config_t'(store_field(store_q, `CFG_WORD));
         dac_regs.offset        <= store_field(store_q, `OFFSET_WORD);
         dac_regs.offset_tempco <= store_field(store_q, `OTC_WORD);
         dac_regs.span          <= store_field(store_q, `SPAN_WORD);
         dac_regs.span_tempco   <= store_field(store_q, `STC_WORD);
      end else if (word_ok && is_load(cmd)) begin
         config_reg <= pend_cfg_q;
         dac_regs   <= pend_dac_q;
      end
   end

   // Read: drive enable at once, the bit after the latency
   logic        rd_active_q;
   logic        rd_wait_q;
   logic [6:0]  rd_addr_q;
   logic [31:0] rd_cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_active_q <= 1'b0;
         rd_wait_q   <= 1'b0;
         rd_addr_q   <= '0;
         rd_cnt_q    <= '0;
      end else if (cs_fall || !cs_s_q) begin
         rd_active_q <= 1'b0;
         rd_wait_q   <= 1'b0;
      end else if (word_ok && cmd == CMD_READ) begin
         rd_active_q <= 1'b1;
         rd_wait_q   <= 1'b1;
         rd_addr_q   <= bit_addr;
         rd_cnt_q    <= '0;
      end else if (rd_wait_q) begin
         if (rd_cnt_q == 32'(READ_LATENCY_CYC - 1)) begin
            rd_wait_q <= 1'b0;
         end else begin
            rd_cnt_q <= rd_cnt_q + 32'd1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_line_out  <= 1'b0;
         serial_data_line_oe_n <= 1'b1;
      end else begin
         serial_data_line_oe_n <= ~rd_active_q;
         if (rd_active_q && !rd_wait_q) begin
            serial_data_line_out <= store_q[rd_addr_q];
         end else begin
            serial_data_line_out <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// [tb/trim_port_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module trim_port_monitor
   import trim_port_pkg::*;
#(
   parameter int unsigned READ_LATENCY_CYC = 20,
   parameter int unsigned REFRESH_CYC      = 200
) (
   input wire logic     clk,
   input wire logic     rst_n,
   input wire logic     sclk,
   input wire logic     chip_select,
   input wire logic     write_enable,
   input wire logic     serial_data_line_in,
   input wire logic     serial_data_line_out,
   input wire logic     serial_data_line_oe_n,
   input wire logic     analog_out_en,
   input wire logic     session_open,
   input wire config_t  config_reg,
   input wire dac_set_t dac_regs
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Six samples cover the pin sync plus the output flop
   a_cs_ends_session: assert property (!chip_select [*6] |-> !session_open)
      else $error("session open with select low");
   a_output_enabled: assert property (chip_select [*6] |-> analog_out_en)
      else $error("output not enabled");
   a_read_release: assert property (!chip_select [*6] |-> serial_data_line_oe_n)
      else $error("data line still driven");
   a_quiet_out: assert property (serial_data_line_oe_n |-> !serial_data_line_out)
      else $error("data out high while released");
   a_read_latency: assert property ($fell(serial_data_line_oe_n) |-> session_open ##0 !serial_data_line_out [*8])
      else $error("read bit shown too early");
   a_regs_idle: assert property ((!chip_select && !write_enable) [*8] |-> $stable(config_reg) && $stable(dac_regs))
      else $error("registers changed while idle");
   a_power_up_zero: assert property ($rose(rst_n) |-> config_reg == '0 && dac_regs == '0)
      else $error("registers not zero after reset");
   a_wake_first: assert property ($rose(session_open) |-> analog_out_en)
      else $error("session opened without select");
   c_session: cover property ($rose(session_open));
   c_read: cover property ($fell(serial_data_line_oe_n));
   c_load: cover property ($changed(config_reg) && session_open);
endmodule
bind trim_serial_command_port trim_port_monitor #(
   .READ_LATENCY_CYC(READ_LATENCY_CYC), .REFRESH_CYC(REFRESH_CYC)
) mon (
   .clk(clk), .rst_n(rst_n), .sclk(sclk), .chip_select(chip_select), .write_enable(write_enable),
   .serial_data_line_in(serial_data_line_in), .serial_data_line_out(serial_data_line_out),
   .serial_data_line_oe_n(serial_data_line_oe_n), .analog_out_en(analog_out_en),
   .session_open(session_open), .config_reg(config_reg), .dac_regs(dac_regs)
);
`default_nettype wire

// [tb/trim_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module trim_host_model (
   output logic     chip_select,
   output logic     sclk,
   output logic     data_line,
   input wire logic dev_out,
   input wire logic dev_oe_n
);
   logic host_bit;
   // Device wins the line while it drives
   assign data_line = dev_oe_n ? host_bit : dev_out;
   initial begin
      chip_select = 1'b0;
      sclk = 1'b0;
      host_bit = 1'b0;
   end
   // Serial clock only runs inside a burst
   task automatic send_bits(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         host_bit = v[i];
         #16 sclk = 1'b1;
         #16 sclk = 1'b0;
      end
      host_bit = ~host_bit;
      // Released line shows the inverse; hold it so a following burst sets the bit later
      #8;
   endtask
   task automatic open_session(input logic u, input logic ok);
      #43 chip_select = 1'b1;
      #64 send_bits({10'h0, 1'b0, u, ~ok, 3'b101}, 6);
   endtask
   // Settle gap scaled down; the bench store model acts at once
   task automatic send_word(input logic [15:0] w);
      send_bits(w, 16);
      #96;
   endtask
   task automatic close_session;
      #40 chip_select = 1'b0;
      #100;
   endtask
endmodule
`default_nettype wire

// [tb/trim_serial_command_port_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module trim_serial_command_port_tb;
   import trim_port_pkg::*;
   localparam int RLAT = 20;
   logic         clk, rst_n, write_enable, chip_select, sclk, line, d_out, d_oe_n, inhibit;
   logic         sess, aout;
   config_t      cfg;
   dac_set_t     dacs;
   logic [127:0] store;
   logic [11:0]  act [5];
   logic [11:0]  pend [5];
   logic [3:0]   lc [5] = '{4'h6, 4'h7, 4'hd, 4'he, 4'hf};
   logic [6:0]   prog_q [$];
   logic [31:0]  lf;
   int           error_cnt, checks_done;
   trim_serial_command_port #(.READ_LATENCY_CYC(RLAT), .REFRESH_CYC(200)) uut (
      .clk(clk), .rst_n(rst_n), .sclk(sclk), .chip_select(chip_select), .write_enable(write_enable),
      .serial_data_line_in(line), .serial_data_line_out(d_out), .serial_data_line_oe_n(d_oe_n),
      .analog_out_en(aout), .session_open(sess), .config_reg(cfg), .dac_regs(dacs)
   );
   trim_host_model host (
      .chip_select(chip_select), .sclk(sclk), .data_line(line), .dev_out(d_out), .dev_oe_n(d_oe_n)
   );
   initial clk = 1'b0;
   always #4 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp_regs;
      #1 checks_done++;
      if (cfg !== config_t'(act[0]) || dacs !== {act[4], act[3], act[2], act[1]}) begin
         error_cnt++;
         $display("mismatch %0t regs %h %h", $time, cfg, dacs);
      end
   endtask
   task automatic cmp_bit(input logic exp);
      #1 checks_done++;
      if (d_oe_n !== 1'b0 || d_out !== exp) begin
         error_cnt++;
         $display("mismatch %0t read bit %b", $time, d_out);
      end
   endtask
   task automatic cmp_link(input logic exp_open, input logic exp_en);
      #1 checks_done++;
      if (sess !== exp_open || aout !== exp_en || (!exp_en && d_oe_n !== 1'b1)) begin
         error_cnt++;
         $display("mismatch %0t link flags %b %b %b", $time, sess, aout, d_oe_n);
      end
   endtask
   task automatic reload;
      for (int k = 0; k < 5; k++) begin
         act[k] = store[k*16 +: 12];
         pend[k] = act[k];
      end
   endtask
   task automatic open_s(input logic u, input logic ok);
      if (!inhibit)
         reload();
      host.open_session(u, ok);
      if (ok)
         inhibit = u;
      repeat (8) @(posedge clk);
      cmp_link(ok, 1'b1);
   endtask
   task automatic close_s;
      host.close_session();
      repeat (8) @(posedge clk);
      cmp_link(1'b0, 1'b0);
   endtask
   task automatic word(input logic [3:0] c, input logic [11:0] d);
      host.send_word({c, d});
      case (c) inside
         4'h1: if (write_enable) store = '0;
         4'h2: if (write_enable) store[d[6:0]] = 1'b1;
         [4'h8:4'hc]: pend[c - 4'h8] = d;
         4'h6, 4'h7, [4'hd:4'hf]: act = pend;
         default: ;
      endcase
      repeat (8) @(posedge clk);
   endtask
   task automatic read_bit(input logic [6:0] a);
      int n;
      open_s(1'b1, 1'b1);
      host.send_bits({4'h3, 5'h1f, a}, 16);
      n = 0;
      while (d_oe_n !== 1'b0 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      repeat (RLAT + 8) @(posedge clk);
      cmp_bit(store[a]);
      close_s();
   endtask
   initial begin
      rst_n = 1'b0;
      write_enable = 1'b0;
      inhibit = 1'b0;
      store = '0;
      lf = 32'h4094;
      error_cnt = 0;
      checks_done = 0;
      reload();
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      cmp_regs();
      open_s(1'b1, 1'b1);
      for (int k = 0; k < 5; k++) begin
         lf = lfsr(lf);
         word(4'h8 + 4'(k), lf[11:0] & (k == 0 ? 12'hf9f : 12'hfff));
      end
      cmp_regs();
      foreach (lc[i]) begin
         lf = lfsr(lf);
         word(4'h8, lf[11:0] & 12'hf9f);
         word(lc[i], 12'h000);
         cmp_regs();
      end
      word(4'h0, 12'hfff);
      word(4'h4, 12'hfff);
      word(4'h2, 12'h003);
      word(4'h1, 12'h000);
      cmp_regs();
      close_s();
      open_s(1'b0, 1'b1);
      cmp_regs();
      close_s();
      open_s(1'b1, 1'b1);
      cmp_regs();
      close_s();
      read_bit(7'd3);
      #1 write_enable = 1'b1;
      for (int p = 0; p < 2; p++) begin
         open_s(1'b1, 1'b1);
         word(4'h1, 12'hfff);
         word(4'h5, 12'h000);
         for (int k = 0; k < 6; k++) begin
            lf = lfsr(lf);
            prog_q.push_back(lf[6:0] % 7'd80);
            word(4'h2, {lf[11:7], prog_q[$]});
            word(4'h5, {5'h00, prog_q[$]});
         end
         close_s();
         repeat (300) @(posedge clk);
         reload();
         cmp_regs();
      end
      for (int i = 4; i < 10; i++)
         read_bit(prog_q[i]);
      #1 write_enable = 1'b0;
      host.send_bits(16'h8fff, 16);
      host.send_bits(16'h6000, 16);
      repeat (8) @(posedge clk);
      cmp_regs();
      open_s(1'b0, 1'b0);
      host.send_word(16'h8fff);
      host.send_word(16'h6000);
      close_s();
      cmp_regs();
      report_and_stop();
   end
   initial begin
      #600000;
      error_cnt++;
      $display("mismatch %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule
`default_nettype wire
